// >>> nfc_ctrl.sv
// nfc_ctrl.sv: host controller driving a byte-wide nand flash over its pins
// assumes: device pins pulled and resolved outside; one 25 MHz clock
`default_nettype none
`include "nfc_defs.svh"

module nfc_ctrl #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk, // clock
  input wire logic resetn, // async reset, active low
  input wire nfc_pkg::nfc_req_s req, // operation request
  input wire logic req_valid, // req offered
  output logic req_ready, // idle, req taken
  input wire logic [7:0] wr_data, // page data byte
  input wire logic wr_valid, // wr_data offered
  output logic wr_ready, // fifo room
  output logic [7:0] rd_data, // byte read from device
  output logic rd_valid, // rd_data pulse
  output logic done, // operation finished pulse
  output logic dev_ready, // filtered ready line level
  input wire logic allow_write, // level: lift program guard
  output nfc_pkg::nfc_pins_s pins, // strobes, selects, data out
  input wire logic [7:0] data_pins_i, // data pins level
  input wire logic ready_busy_n // open-drain ready line level
);
  import nfc_pkg::*;

  nfc_ctrl_s q;
  nfc_ctrl_s n;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic cmd_ok;

  ////////////////////////////////////////////////////////////////////////////
  nfc_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // address byte i of a 27-bit address, bit 8 never sent
  function automatic logic [7:0] nfc_addr_byte(input logic [`NFC_ADDR_W-1:0] a,
                                               input logic [1:0] i);
    case (i)
      2'h0: nfc_addr_byte = a[`NFC_COL_LSB +: 8];
      2'h1: nfc_addr_byte = a[`NFC_PAGE_LSB +: 8];
      2'h2: nfc_addr_byte = a[`NFC_HI_LSB +: 8];
      default: nfc_addr_byte = {6'h00, a[`NFC_TOP_LSB +: 2]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // of the commands, only status and reset may reach a busy device; address, data and read cycles are not held
  assign cmd_ok = q.rb_ready || (q.req.data == `NFC_CMD_STATUS) ||
                  (q.req.data == `NFC_CMD_RESET);
  // guard must not drop on the edge that lowers the write strobe
  assign fifo_pop = (q.st == S_GATE) && (q.req.op == NFC_OP_WRITE) &&
                    fifo_valid && q.pins.wp_n && allow_write;

  always_comb
  begin
    n = q;
    n.done = 1'b0;
    n.rd_valid = 1'b0;
    n.pins.wp_n = allow_write;
    n.rb_s1 = ready_busy_n;
    n.rb_s2 = q.rb_s1;
    n.rb_s3 = q.rb_s2;
    if (q.rb_s2 == q.rb_s3)
      n.rb_ready = q.rb_s3;
    n.dq_s1 = data_pins_i;
    n.dq_s2 = q.dq_s1;
    n.dq_s3 = q.dq_s2;
    case (q.st)
      S_IDLE:
      begin
        if (req_valid && q.req_ready)
        begin
          n.req = req;
          n.idx = 2'h0;
          n.cnt = req.count;
          n.pins.ce_n = 1'b0;
          n.st = S_GATE;
        end
      end
      S_GATE:
      begin
        case (q.req.op)
          NFC_OP_CMD:
            if (cmd_ok)
            begin
              n.pins.cle = 1'b1;
              n.pins.data_pins_o = q.req.data;
              n.pins.data_pins_oe_n = 1'b0;
              n.pins.we_n = 1'b0;
              n.st = S_WLO;
            end
          NFC_OP_ADDR:
          begin
            n.pins.ale = 1'b1;
            n.pins.data_pins_o = nfc_addr_byte(q.req.addr, q.idx);
            n.pins.data_pins_oe_n = 1'b0;
            n.pins.we_n = 1'b0;
            n.st = S_WLO;
          end
          NFC_OP_WRITE:
            if (fifo_pop)
            begin
              // data bytes go out with both latches low and guard high
              n.pins.data_pins_o = fifo_data;
              n.pins.data_pins_oe_n = 1'b0;
              n.pins.we_n = 1'b0;
              n.st = S_WLO;
            end
          NFC_OP_READ:
          begin
            n.pins.data_pins_oe_n = 1'b1;
            n.pins.output_strobe_n = 1'b0;
            n.phase = 2'h0;
            n.st = S_RLO;
          end
          NFC_OP_WAIT:
          begin
            n.cnt = `NFC_CNT_W'(`NFC_WB_CYC);
            n.st = S_WAIT;
          end
          default: n.st = S_IDLE;
        endcase
      end
      S_WLO:
      begin
        n.pins.we_n = 1'b1;
        n.st = S_WHI;
      end
      S_WHI:
      begin
        n.st = S_GATE;
        if (q.req.op == NFC_OP_ADDR)
        begin
          if (q.idx == 2'(`NFC_ADDR_CYCLES - 1))
            n.st = S_IDLE;
          else
            n.idx = 2'(q.idx + 2'h1);
        end
        else if (q.req.op == NFC_OP_WRITE)
        begin
          if (q.cnt <= `NFC_CNT_W'(1))
            n.st = S_IDLE;
          else
            n.cnt = `NFC_CNT_W'(q.cnt - 1'b1);
        end
        else
          n.st = S_IDLE;
        if (n.st == S_IDLE)
        begin
          n.pins.cle = 1'b0;
          n.pins.ale = 1'b0;
          n.pins.data_pins_oe_n = 1'b1;
        end
      end
      S_RLO:
      begin
        n.phase = 2'(q.phase + 2'h1);
        if (q.phase == 2'(`NFC_RD_LOW_CYC - 1))
        begin
          n.pins.output_strobe_n = 1'b1;
          n.st = S_RHI;
        end
      end
      S_RHI:
        if (q.dq_s2 == q.dq_s3)
        begin
          n.rd_data = q.dq_s3;
          n.rd_valid = 1'b1;
          if (q.cnt <= `NFC_CNT_W'(1))
            n.st = S_IDLE;
          else
          begin
            n.cnt = `NFC_CNT_W'(q.cnt - 1'b1);
            n.st = S_GATE;
          end
        end
      S_WAIT:
        if (q.cnt != '0)
          n.cnt = `NFC_CNT_W'(q.cnt - 1'b1);
        else if (q.rb_ready)
          n.st = S_IDLE;
      default: n.st = S_IDLE;
    endcase
    if (q.st != S_IDLE && n.st == S_IDLE)
    begin
      n.done = 1'b1;
      // releasing select lets an idle device drop to standby
      n.pins.ce_n = q.req.last;
    end
    n.req_ready = (n.st == S_IDLE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.pins.ce_n <= 1'b1;
      q.pins.we_n <= 1'b1;
      q.pins.output_strobe_n <= 1'b1;
      q.pins.data_pins_oe_n <= 1'b1;
      q.req_ready <= 1'b1;
    end
    else
      q <= n;
  end

  assign req_ready = q.req_ready;
  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;
  assign done = q.done;
  assign dev_ready = q.rb_ready;
  assign pins = q.pins;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_addr_top_low: assert property (
    (q.pins.ale && !q.pins.we_n && q.idx == 2'h3) |-> q.pins.data_pins_o[7:2] == 6'h00)
    else $error("upper address bits not low in fourth cycle");
  a_busy_cmd_legal: assert property (
    (q.pins.cle && !q.pins.we_n && !$past(q.rb_ready)) |->
    (q.pins.data_pins_o == `NFC_CMD_STATUS || q.pins.data_pins_o == `NFC_CMD_RESET))
    else $error("illegal command sent to busy device");
  a_write_sel_levels: assert property (
    !q.pins.we_n |-> (!q.pins.ce_n && q.pins.output_strobe_n && !q.pins.data_pins_oe_n))
    else $error("write strobe without select or with read strobe");
  a_data_guard_high: assert property (
    (!q.pins.we_n && !q.pins.cle && !q.pins.ale) |-> q.pins.wp_n)
    else $error("page data written with guard low");
  a_we_pulse_shape: assert property (
    $fell(q.pins.we_n) |=> q.pins.we_n [*2])
    else $error("write strobe pulse wrong");
  a_addr_four_cycles: assert property (
    $rose(q.pins.ale) |-> q.pins.ale [*8] ##1 q.pins.ale [*3] ##1 !q.pins.ale)
    else $error("address phase not four byte cycles");
  a_read_strobe_len: assert property (
    $fell(q.pins.output_strobe_n) |-> (!q.pins.output_strobe_n) [*3] ##1
    q.pins.output_strobe_n ##[1:40] q.rd_valid)
    else $error("read strobe shape or capture wrong");
  a_no_drive_read: assert property (
    !q.pins.output_strobe_n |-> q.pins.data_pins_oe_n)
    else $error("controller drives data pins during read");
  a_busy_wait_min: assert property (
    (q.st == S_GATE && q.req.op == NFC_OP_WAIT) |=> (q.st == S_WAIT) [*4])
    else $error("busy wait shorter than write-to-busy time");

  c_page_write: cover property (q.done && q.req.op == NFC_OP_WRITE);
  c_page_read: cover property (q.rd_valid && q.req.op == NFC_OP_READ);
  c_busy_wait: cover property (q.done && q.req.op == NFC_OP_WAIT && $past(!q.rb_ready, 2));
  c_status_busy: cover property (q.pins.cle && !q.pins.we_n && !q.rb_ready);

endmodule

`default_nettype wire

// >>> nfc_defs.svh
// nfc_defs.svh: constants of the nand flash command interface controller
// assumes: included by the package and the controller, 25 MHz clock
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH

`define NFC_CMD_SERIAL_IN 8'h80
`define NFC_CMD_READ_A 8'h00
`define NFC_CMD_READ_B 8'h01
`define NFC_CMD_READ_C 8'h50
`define NFC_CMD_RESET 8'hFF
`define NFC_CMD_PROGRAM 8'h10
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_GO 8'hD0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_IDENT 8'h90

`define NFC_PAGE_BYTES 528
`define NFC_MAIN_BYTES 512
`define NFC_SPARE_BYTES 16
`define NFC_ADDR_CYCLES 4
`define NFC_ADDR_W 27
`define NFC_CNT_W 10

// address byte field positions
`define NFC_COL_LSB 0
`define NFC_PAGE_LSB 9
`define NFC_HI_LSB 17
`define NFC_TOP_LSB 25

`define NFC_CLK_NS 40
`define NFC_T_WB_NS 100
`define NFC_WB_CYC ((`NFC_T_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_RD_LOW_CYC 3

`endif

// >>> nfc_dev_model.sv
// nfc_dev_model.sv: behavioural byte-wide nand flash seen at its pins
// assumes: bench resolves the open-drain ready line and the data pins
`default_nettype none

module nfc_dev_model #(
  parameter int BUSY_NS = 2000, // array work interval
  parameter logic [7:0] ID_A = 8'h3C, // arbitrary identification byte
  parameter logic [7:0] ID_B = 8'hC3 // arbitrary identification byte
) (
  input wire logic cle, // command latch select
  input wire logic ale, // address latch select
  input wire logic ce_n, // chip select
  input wire logic we_n, // write strobe
  input wire logic output_strobe_n, // read strobe
  input wire logic wp_n, // program guard
  input wire logic [7:0] dq_i, // data pins level
  output logic [7:0] dq_o, // byte offered
  output logic dq_oe, // drives the data pins
  output logic rb_low, // pulls the ready line low
  output logic [26:0] last_addr, // last address taken
  output logic [7:0] viol // slips seen at the pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:527];
  logic [7:0] cmd, hold;
  logic [9:0] col;
  logic [1:0] idx;
  logic stat, ident, idn, standby;
  logic busy = 1'b0;
  time until_t;
  //////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 528; i++) mem[i] = 8'(i >> 2) ^ 8'(i);
    {cmd, hold, col, idx, stat, ident, idn, last_addr, viol} = '0;
    until_t = 0;
  end
  always #10 busy = ($time < until_t);
  assign rb_low = busy;
  assign standby = ce_n && !busy;
  assign dq_o = hold;
  assign dq_oe = !ce_n && !output_strobe_n;
  //////////////////////////////////////////////////////////////////
  always @(posedge we_n) if (!ce_n && output_strobe_n)
  begin
    if (cle)
    begin
      if (busy && dq_i != 8'h70 && dq_i != 8'hFF) viol = viol + 8'h01;
      else case (dq_i)
        8'h00, 8'h01, 8'h50, 8'h80, 8'h60:
        begin
          cmd = dq_i;
          idx = 2'h0;
          stat = 1'b0;
          ident = 1'b0;
        end
        8'h10: if (cmd == 8'h80 && wp_n) until_t = $time + BUSY_NS;
        8'hD0: if (cmd == 8'h60 && wp_n) until_t = $time + BUSY_NS;
        8'h70: stat = 1'b1;
        8'h90:
        begin
          ident = 1'b1;
          idn = 1'b0;
          stat = 1'b0;
        end
        8'hFF:
        begin
          until_t = $time;
          stat = 1'b0;
        end
        default: ;
      endcase
    end
    else if (ale)
    begin
      case (idx)
        2'h0: last_addr[7:0] = dq_i;
        2'h1: last_addr[16:9] = dq_i;
        2'h2: last_addr[24:17] = dq_i;
        default:
        begin
          last_addr[26:25] = dq_i[1:0];
          if (dq_i[7:2] != 6'h00) viol = viol + 8'h01;
        end
      endcase
      last_addr[8] = (cmd == 8'h01);
      if (idx == 2'h3)
      begin
        col = (cmd == 8'h01) ? 10'h100 + 10'(last_addr[7:0]) :
          (cmd == 8'h50) ? 10'h200 + 10'(last_addr[3:0]) : 10'(last_addr[7:0]);
        if (cmd inside {8'h00, 8'h01, 8'h50}) until_t = $time + BUSY_NS;
      end
      idx = idx + 2'h1;
    end
    else if (wp_n && cmd == 8'h80)
    begin
      mem[col] = dq_i;
      col = col + 10'h001;
    end
  end
  //////////////////////////////////////////////////////////////////
  always @(negedge output_strobe_n) if (!ce_n && !cle && !ale)
  begin
    if (stat) hold = {wp_n, !busy, 5'h00, 1'b0};
    else if (ident)
    begin
      hold = idn ? ID_B : ID_A;
      idn = 1'b1;
    end
    else if (!busy)
    begin
      hold = mem[col];
      col = (col == 10'h20F) ? ((cmd == 8'h50) ? 10'h200 : 10'h000) : col + 10'h001;
    end
  end
endmodule

`default_nettype wire

// >>> nfc_fifo.sv
// nfc_fifo.sv: small write-data fifo with valid and ready on both sides
// assumes: one clock, asynchronous active-low reset
`default_nettype none

module nfc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk, // clock
  input wire logic resetn, // async reset, active low
  input wire logic [W-1:0] in_data, // byte to store
  input wire logic in_valid, // in_data offered
  output logic in_ready, // room for a byte
  output logic [W-1:0] out_data, // oldest byte
  output logic out_valid, // a byte is held
  input wire logic out_ready // oldest byte taken
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic in_ready;
  } nfc_fifo_s;

  nfc_fifo_s q;
  nfc_fifo_s n;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nfc_bump(input logic [AW-1:0] p);
    nfc_bump = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = q.in_ready;
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid && q.in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    n = q;
    if (push)
    begin
      n.mem[q.wr] = in_data;
      n.wr = nfc_bump(q.wr);
    end
    if (pop)
      n.rd = nfc_bump(q.rd);
    if (push && !pop)
      n.cnt = CW'(q.cnt + 1'b1);
    else if (pop && !push)
      n.cnt = CW'(q.cnt - 1'b1);
    n.in_ready = (n.cnt != CW'(D));
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.in_ready <= 1'b1;
    end
    else
      q <= n;
  end

endmodule

`default_nettype wire

// >>> nfc_pkg.sv
// nfc_pkg.sv: types of the nand flash command interface controller
// assumes: nfc_defs.svh on the include path
`default_nettype none
`include "nfc_defs.svh"

package nfc_pkg;

  typedef enum logic [2:0] {NFC_OP_CMD, NFC_OP_ADDR, NFC_OP_WRITE, NFC_OP_READ,
                            NFC_OP_WAIT} nfc_op_e;

  typedef struct packed {
    nfc_op_e op;
    logic [7:0] data;
    logic [`NFC_ADDR_W-1:0] addr;
    logic [`NFC_CNT_W-1:0] count;
    logic last;
  } nfc_req_s;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic data_pins_oe_n;
    logic [7:0] data_pins_o;
  } nfc_pins_s;

  typedef enum logic [2:0] {S_IDLE, S_GATE, S_WLO, S_WHI, S_RLO, S_RHI,
                            S_WAIT} nfc_state_e;

  typedef struct packed {
    nfc_state_e st;
    nfc_req_s req;
    nfc_pins_s pins;
    logic [1:0] idx;
    logic [`NFC_CNT_W-1:0] cnt;
    logic [1:0] phase;
    logic rb_s1;
    logic rb_s2;
    logic rb_s3;
    logic rb_ready;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] dq_s3;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic req_ready;
  } nfc_ctrl_s;

endpackage

`default_nettype wire

// >>> tb_nfc_ctrl.sv
// tb_nfc_ctrl.sv: self-checking bench of the nand flash controller
// assumes: nfc_dev_model stands on the pins; 25 MHz clock
`default_nettype none

module tb_nfc_ctrl;
  import nfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_A = 8'h3C; // arbitrary
  localparam logic [7:0] ID_B = 8'hC3; // arbitrary
  logic clk = 0, resetn = 0, req_valid = 0, wr_valid = 0, allow_write = 1;
  logic req_ready, wr_ready, rd_valid, done, dev_ready, dq_oe, rb_low, ready_busy_n;
  logic [7:0] wr_data = 0, rd_data, dq_o, viol, data_pins_i, flt = 0;
  logic [26:0] last_addr;
  nfc_req_s req = '0;
  nfc_pins_s pins;
  logic [7:0] exp_q [$];
  int miscompares = 0, total_checks = 0;
  //////////////////////////////////////////////////////////////////
  nfc_ctrl #(.FIFO_DEPTH(4)) u_dut (.clk(clk), .resetn(resetn), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
    .dev_ready(dev_ready), .allow_write(allow_write), .pins(pins),
    .data_pins_i(data_pins_i), .ready_busy_n(ready_busy_n));
  nfc_dev_model #(.ID_A(ID_A), .ID_B(ID_B)) u_dev (.cle(pins.cle), .ale(pins.ale),
    .ce_n(pins.ce_n), .we_n(pins.we_n), .output_strobe_n(pins.output_strobe_n), .wp_n(pins.wp_n),
    .dq_i(data_pins_i), .dq_o(dq_o), .dq_oe(dq_oe), .rb_low(rb_low),
    .last_addr(last_addr), .viol(viol));
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
  assign data_pins_i = !pins.data_pins_oe_n ? pins.data_pins_o : dq_oe ? dq_o : flt;
  always @(posedge clk) flt <= flt + 8'h5B;
  initial forever #20 clk = ~clk;
  //////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_val({24'h0, got}, {24'h0, exp});
  endtask
  always @(posedge clk) if (rd_valid === 1'b1)
    cmp_byte(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  task automatic op(nfc_op_e o, logic [7:0] d, logic [26:0] a, int n, logic l);
    int k;
    k = 0;
    req <= '{o, d, a, n[9:0], l};
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin @(posedge clk); k++; end while (done !== 1'b1 && k < 5000);
    if (k >= 5000) cmp_val(0, 1);
  endtask
  task automatic stat(logic [7:0] e);
    exp_q.push_back(e);
    op(NFC_OP_CMD, 8'h70, 0, 0, 0);
    op(NFC_OP_READ, 0, 0, 1, 1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] wb [4];
    logic [7:0] m, c;
    logic [26:0] a;
    int base;
    void'($urandom(32'h9EBD));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // fill the fifo until it refuses, then program four bytes at column 10
    for (int k = 0; k < 4; k++)
    begin
      wb[k] = 8'($urandom);
      wr_data <= wb[k];
      wr_valid <= 1'b1;
      do @(posedge clk); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_val(32'(wr_ready), 0);
    a = {18'($urandom), 1'b0, 8'h0A};
    op(NFC_OP_CMD, 8'h80, 0, 0, 0);
    op(NFC_OP_ADDR, 0, a, 0, 0);
    cmp_val(32'(last_addr), 32'(a));
    op(NFC_OP_WRITE, 0, 0, 4, 0);
    op(NFC_OP_CMD, 8'h10, 0, 0, 0);
    op(NFC_OP_WAIT, 0, 0, 0, 1);
    cmp_val(32'(dev_ready), 1);
    stat(8'hC0);
    // each read mode from a random column, then mode 00 from column 10 for the programmed bytes
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 1) ? 8'h01 : (i == 2) ? 8'h50 : 8'h00;
      c = (i == 3) ? 8'h0A : 8'(16 + $urandom % 200) & 8'hFB;
      a = {18'($urandom), 1'b1, c};
      base = (m == 8'h01) ? 256 + c : (m == 8'h50) ? 512 + c[3:0] : c;
      for (int k = 0; k < 4; k++)
        exp_q.push_back((i == 3) ? wb[k] : 8'((base + k) >> 2) ^ 8'(base + k));
      op(NFC_OP_CMD, m, 0, 0, 0);
      op(NFC_OP_ADDR, 0, a, 0, 0);
      cmp_val(32'(last_addr), 32'({a[26:9], m == 8'h01, a[7:0]}));
      op(NFC_OP_WAIT, 0, 0, 0, 0);
      op(NFC_OP_READ, 0, 0, 4, 1);
    end
    exp_q.push_back(ID_A);
    exp_q.push_back(ID_B);
    op(NFC_OP_CMD, 8'h90, 0, 0, 0);
    op(NFC_OP_READ, 0, 0, 2, 1);
    // status while programming, then reset cuts the program short
    op(NFC_OP_CMD, 8'h80, 0, 0, 0);
    op(NFC_OP_ADDR, 0, a, 0, 0);
    op(NFC_OP_CMD, 8'h10, 0, 0, 1);
    stat(8'h80);
    cmp_val(32'(dev_ready), 0);
    op(NFC_OP_CMD, 8'hFF, 0, 0, 1);
    stat(8'hC0);
    // a low guard blocks erase
    allow_write <= 1'b0;
    op(NFC_OP_CMD, 8'h60, 0, 0, 0);
    op(NFC_OP_ADDR, 0, a, 0, 0);
    op(NFC_OP_CMD, 8'hD0, 0, 0, 1);
    stat(8'h40);
    allow_write <= 1'b1;
    op(NFC_OP_CMD, 8'h60, 0, 0, 0);
    op(NFC_OP_ADDR, 0, a, 0, 0);
    op(NFC_OP_CMD, 8'hD0, 0, 0, 1);
    stat(8'h80);
    // read command given while busy waits for ready; column 10 holds the programmed byte
    exp_q.push_back(wb[0]);
    op(NFC_OP_CMD, 8'h00, 0, 0, 0);
    op(NFC_OP_ADDR, 0, a, 0, 0);
    op(NFC_OP_WAIT, 0, 0, 0, 0);
    op(NFC_OP_READ, 0, 0, 1, 1);
    repeat (4) @(posedge clk);
    cmp_val(32'(viol), 0);
    cmp_val(exp_q.size(), 0);
    report_and_stop();
  end
endmodule

`default_nettype wire
